// File: pcc_bcd_field.sv
// One BCD field that steps by one and wraps from its top to its bottom.
`timescale 1ns/1ps
module pcc_bcd_field
  import pcc_pkg::*;
(
  // Field state and limits
  input wire pcc_pkg::pcc_bcd_t value,
  input wire pcc_pkg::pcc_bcd_t lo,
  input wire pcc_pkg::pcc_bcd_t hi,
  // Stepped value and wrap indication
  output pcc_pkg::pcc_bcd_t next_value,
  output logic at_max
);

  localparam logic [3:0] ONE = 4'h1;
  localparam logic [3:0] ZERO = 4'h0;

  // The wrap test uses the limit, so a short month wraps the date early.
  wire ones_top = (value[3:0] == BCD_DIGIT_MAX);
  assign at_max = (value >= hi);
  assign next_value = at_max ? lo :
                      ones_top ? {value[7:4] + ONE, ZERO} :
                      {value[7:4], value[3:0] + ONE};

endmodule : pcc_bcd_field

// File: pcc_calendar_clock.sv
// Calendar clock core: second count, BCD carry chain, preset and scan delivery.
`timescale 1ns/1ps
module pcc_calendar_clock
  import pcc_pkg::*;
#(
  parameter longint SEC_CYCLES = pcc_pkg::SECOND_CYCLES
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Power and fitting state
  input wire logic main_power_ok,
  input wire logic module_fitted,
  // Scan delivery
  input wire logic scan_req,
  output pcc_pkg::pcc_time_s scan_time,
  output logic scan_valid,
  // Preset write
  input wire logic preset_req,
  input wire pcc_pkg::pcc_time_s preset_time,
  output pcc_pkg::pcc_stat_e preset_status,
  output logic preset_done,
  // Status
  output logic [pcc_pkg::WARN_W-1:0] summary_warning_word,
  output logic clock_fault
);

  import pcc_pkg::*;

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  localparam int CNT_W = $clog2(SEC_CYCLES + 1);
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(SEC_CYCLES - 1);
  localparam logic [CNT_W-1:0] CNT_ZERO = '0;
  localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);

  if (SEC_CYCLES < 2)
    $error("SEC_CYCLES must be at least 2");

  // ----------------------------------------------------------------
  // Calendar helpers
  // ----------------------------------------------------------------
  localparam pcc_bcd_t M_FEB = 8'h02;
  localparam pcc_bcd_t M_APR = 8'h04;
  localparam pcc_bcd_t M_JUN = 8'h06;
  localparam pcc_bcd_t M_SEP = 8'h09;
  localparam pcc_bcd_t M_NOV = 8'h11;
  localparam pcc_bcd_t D_28 = 8'h28;
  localparam pcc_bcd_t D_29 = 8'h29;
  localparam pcc_bcd_t D_30 = 8'h30;
  localparam pcc_bcd_t D_31 = 8'h31;
  localparam pcc_bcd_t Y_00 = 8'h00;

  // A BCD pair is a multiple of four by its tens parity and its ones digit.
  function automatic logic bcd_div4(pcc_bcd_t v);
    if (v[4])
      bcd_div4 = (v[3:0] == 4'h2) || (v[3:0] == 4'h6);
    else
      bcd_div4 = (v[3:0] == 4'h0) || (v[3:0] == 4'h4) || (v[3:0] == 4'h8);
  endfunction : bcd_div4

  // Last date of the month; a year 00 leaps only when the century does.
  function automatic pcc_bcd_t month_last(pcc_bcd_t m, pcc_bcd_t y, pcc_bcd_t c);
    logic leap;
    leap = (y == Y_00) ? bcd_div4(c) : bcd_div4(y);
    if (m == M_FEB)
      month_last = leap ? D_29 : D_28;
    else if (m == M_APR || m == M_JUN || m == M_SEP || m == M_NOV)
      month_last = D_30;
    else
      month_last = D_31;
  endfunction : month_last

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  pcc_time_s now;
  logic [CNT_W-1:0] sec_cnt;

  // ----------------------------------------------------------------
  // Second timebase
  // ----------------------------------------------------------------
  // The timebase ignores main power; in the real part it sits on the
  // backup store, so a drop of any length, 20 ms included, loses nothing.
  wire held_ok = pcc_time_ok(now);
  wire tick = (sec_cnt == CNT_LAST) && held_ok;
  wire [CNT_W-1:0] next_sec_cnt = (!held_ok || sec_cnt == CNT_LAST) ? CNT_ZERO
                                   : sec_cnt + CNT_ONE;

  // ----------------------------------------------------------------
  // Carry chain
  // ----------------------------------------------------------------
  // Chain order from the fastest field up to the century.
  localparam int CHAIN_N = 7;
  // Position of the date in the chain; the weekday turns with it.
  localparam int DATE_LINK = 3;
  localparam int CHAIN [CHAIN_N] = '{F_SECOND, F_MINUTE, F_HOUR, F_DATE,
                                     F_MONTH, F_YEAR, F_CENTURY};

  logic [CHAIN_N-1:0] step_en;
  logic [CHAIN_N-1:0] wrap;
  pcc_bcd_t stepped [CHAIN_N];
  pcc_time_s counted;

  wire pcc_bcd_t date_hi = month_last(now.field[F_MONTH], now.field[F_YEAR],
                                      now.field[F_CENTURY]);

  genvar k;
  generate
    for (k = 0; k < CHAIN_N; k++)
    begin : g_chain
      wire pcc_bcd_t hi_k = (CHAIN[k] == F_DATE) ? date_hi : FIELD_HI[CHAIN[k]];
      if (k == 0)
      begin : g_first
        assign step_en[k] = tick;
      end
      else
      begin : g_next
        assign step_en[k] = step_en[k-1] & wrap[k-1];
      end
      pcc_bcd_field u_field (
        .value(now.field[CHAIN[k]]),
        .lo(FIELD_LO[CHAIN[k]]),
        .hi(hi_k),
        .next_value(stepped[k]),
        .at_max(wrap[k])
      );
      assign counted.field[CHAIN[k]] = step_en[k] ? stepped[k] : now.field[CHAIN[k]];
    end
  endgenerate

  // The weekday turns with the date, i.e. when the hour wraps at midnight.
  wire pcc_bcd_t dow_step;
  pcc_bcd_field u_dow (
    .value(now.field[F_DOW]),
    .lo(FIELD_LO[F_DOW]),
    .hi(FIELD_HI[F_DOW]),
    .next_value(dow_step),
    .at_max()
  );
  assign counted.field[F_DOW] = step_en[DATE_LINK] ? dow_step : now.field[F_DOW];

  // ----------------------------------------------------------------
  // Preset decode
  // ----------------------------------------------------------------
  // Improper data is still stored, as the module would, but it flags a
  // fault and halts counting until the host writes a proper set.
  wire preset_take = preset_req && module_fitted;
  wire preset_ok = pcc_time_ok(preset_time);
  wire pcc_stat_e next_status = !module_fitted ? PCC_ST_ABSENT :
                                preset_ok ? PCC_ST_OK : PCC_ST_BAD;
  wire pcc_time_s next_now = preset_take ? preset_time : counted;
  wire next_fault = !pcc_time_ok(next_now);

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  // Held time and timebase; the reset record has month 00, so a fresh
  // module reports a fault until the host loads a time.
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      now <= '0;
      sec_cnt <= CNT_ZERO;
    end
    else
    begin
      now <= next_now;
      sec_cnt <= preset_take ? CNT_ZERO : next_sec_cnt;
    end
  end

  // Fault flag follows the held data each cycle, so no clear is needed.
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      clock_fault <= 1'b1;
      // The all-zero reset record is improper, so the warning bit starts set too.
      summary_warning_word <= WARN_RESET;
      summary_warning_word[WARN_CLOCK_FAULT_BIT] <= 1'b1;
    end
    else
    begin
      clock_fault <= next_fault;
      summary_warning_word[WARN_CLOCK_FAULT_BIT] <= next_fault;
    end
  end

  // Scan delivery takes a snapshot only while the main unit is powered.
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      scan_time <= '0;
      scan_valid <= 1'b0;
    end
    else
    begin
      scan_valid <= scan_req && main_power_ok;
      if (scan_req && main_power_ok)
        scan_time <= now;
    end
  end

  // Preset answer, one-cycle done pulse with a held status code.
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      preset_status <= PCC_ST_OK;
      preset_done <= 1'b0;
    end
    else
    begin
      preset_done <= preset_req;
      if (preset_req)
        preset_status <= next_status;
    end
  end

endmodule : pcc_calendar_clock

// File: pcc_cpu_model.sv
// Main-unit model that scans the clock at a steady rate.
`timescale 1ns/1ps
module pcc_cpu_model
  import pcc_pkg::*;
#(
  parameter int GAP = 3
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Scan interface
  output logic scan_req,
  input wire pcc_pkg::pcc_time_s scan_time,
  input wire logic scan_valid,
  // Status copy
  output pcc_pkg::pcc_time_s last,
  output int n_rec
);
  int cnt;
  // One request per scan; the copy is only refreshed by a delivered record.
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      cnt <= 0;
      scan_req <= 1'b0;
      n_rec <= 0;
    end
    else
    begin
      cnt <= (cnt == GAP - 1) ? 0 : cnt + 1;
      scan_req <= (cnt == 0);
      if (scan_valid)
      begin
        last <= scan_time;
        n_rec <= n_rec + 1;
      end
    end
  end
endmodule : pcc_cpu_model

// File: pcc_pkg.sv
// Shared constants, types and field checks for the option calendar clock.
package pcc_pkg;

  // ----------------------------------------------------------------
  // Field layout
  // ----------------------------------------------------------------
  localparam int NUM_FIELDS = 8;
  localparam int F_YEAR = 0;
  localparam int F_MONTH = 1;
  localparam int F_DATE = 2;
  localparam int F_HOUR = 3;
  localparam int F_MINUTE = 4;
  localparam int F_SECOND = 5;
  localparam int F_DOW = 6;
  localparam int F_CENTURY = 7;

  typedef logic [7:0] pcc_bcd_t;

  // Eight BCD bytes, element 0 is the year and element 7 the century.
  typedef struct packed {
    pcc_bcd_t [NUM_FIELDS-1:0] field;
  } pcc_time_s;

  // Legal range of each field, indexed like the time record.
  localparam pcc_bcd_t [NUM_FIELDS-1:0] FIELD_LO =
    {8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h00};
  localparam pcc_bcd_t [NUM_FIELDS-1:0] FIELD_HI =
    {8'h99, 8'h06, 8'h59, 8'h59, 8'h23, 8'h31, 8'h12, 8'h99};

  // ----------------------------------------------------------------
  // Preset status and warning word
  // ----------------------------------------------------------------
  typedef enum logic [7:0] {
    PCC_ST_OK = 8'h00,
    PCC_ST_ABSENT = 8'h01,
    PCC_ST_BAD = 8'h02
  } pcc_stat_e;

  localparam int WARN_W = 16;
  localparam int WARN_CLOCK_FAULT_BIT = 4;
  localparam logic [WARN_W-1:0] WARN_RESET = 16'h0000;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam longint CLK_HZ = 100_000_000;
  localparam longint SECOND_S = 1;
  localparam longint SECOND_CYCLES = SECOND_S * CLK_HZ;
  localparam int HOLDOVER_MS = 20;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  localparam logic [3:0] BCD_DIGIT_MAX = 4'h9;

  // True when both digits are decimal and the value lies in range.
  function automatic logic pcc_bcd_ok(pcc_bcd_t v, pcc_bcd_t lo, pcc_bcd_t hi);
    pcc_bcd_ok = (v[7:4] <= BCD_DIGIT_MAX) && (v[3:0] <= BCD_DIGIT_MAX)
                 && (v >= lo) && (v <= hi);
  endfunction : pcc_bcd_ok

  // True when every field of a record is proper.
  function automatic logic pcc_time_ok(pcc_time_s t);
    logic ok;
    ok = 1'b1;
    for (int i = 0; i < NUM_FIELDS; i++)
      ok = ok & pcc_bcd_ok(t.field[i], FIELD_LO[i], FIELD_HI[i]);
    pcc_time_ok = ok;
  endfunction : pcc_time_ok

endpackage : pcc_pkg

// File: pcc_props.sv
// Port checker for the calendar clock.
`timescale 1ns/1ps
module pcc_props
  import pcc_pkg::*;
#(
  parameter longint SEC_CYCLES = 10
)
(
  // Clock, reset and inputs
  input wire logic clk,
  input wire logic reset_n,
  input wire logic main_power_ok,
  input wire logic module_fitted,
  input wire logic scan_req,
  input wire logic preset_req,
  input wire pcc_pkg::pcc_time_s preset_time,
  // Outputs
  input wire pcc_pkg::pcc_time_s scan_time,
  input wire logic scan_valid,
  input wire pcc_pkg::pcc_stat_e preset_status,
  input wire logic preset_done,
  input wire logic [pcc_pkg::WARN_W-1:0] summary_warning_word,
  input wire logic clock_fault
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  // Scan answers follow the request by one cycle; power loss only blocks delivery.
  AST_SCAN_ANS: assert property (scan_req && main_power_ok |=> scan_valid)
    else $error("scan not answered");
  AST_SCAN_REFUSE: assert property (!(scan_req && main_power_ok) |=> !scan_valid)
    else $error("scan answered without request");
  AST_SCAN_HOLD: assert property (!scan_valid |-> $stable(scan_time))
    else $error("record moved without a scan");
  AST_DONE: assert property (preset_req |=> preset_done)
    else $error("preset not acknowledged");
  AST_ABSENT: assert property (
    preset_req && !module_fitted |=> preset_status == PCC_ST_ABSENT)
    else $error("missing module not reported");
  AST_FAULT_MIRROR: assert property (summary_warning_word == {11'h000, clock_fault, 4'h0})
    else $error("warning word disagrees with fault");
  AST_BAD_FAULT: assert property (
    preset_done && preset_status == PCC_ST_BAD |-> clock_fault)
    else $error("improper preset left fault clear");
  AST_OK_CLEAR: assert property (
    preset_done && preset_status == PCC_ST_OK |-> !clock_fault)
    else $error("good preset left fault set");
  AST_PRESET_SEEN: assert property (
    (preset_req && module_fitted) ##1 (scan_req && main_power_ok)
    |=> scan_time == $past(preset_time, 2))
    else $error("preset not delivered");
endmodule : pcc_props

// File: tb_pcc_calendar_clock.sv
// Self-checking bench for the calendar clock.
`timescale 1ns/1ps
module tb_pcc_calendar_clock;
  import pcc_pkg::*;
  localparam longint SEC = 20;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic main_power_ok = 1'b1;
  logic module_fitted = 1'b1;
  logic scan_req;
  logic preset_req = 1'b0;
  pcc_time_s preset_time = '0;
  pcc_time_s scan_time;
  pcc_time_s last;
  pcc_time_s t;
  pcc_time_s got;
  logic scan_valid;
  pcc_stat_e preset_status;
  logic preset_done;
  logic [WARN_W-1:0] summary_warning_word;
  logic clock_fault;
  int n_rec;
  int k;
  int n_fail = 0;
  int comparisons = 0;
  pcc_bcd_t bad_v[9] = '{8'h14, 8'h32, 8'h25, 8'h60, 8'h60, 8'h07, 8'h00, 8'h00, 8'h1A};
  int bad_f[9] = '{F_MONTH, F_DATE, F_HOUR, F_MINUTE, F_SECOND, F_DOW, F_MONTH, F_DATE, F_YEAR};
  pcc_calendar_clock #(.SEC_CYCLES(SEC)) dut (.clk(clk), .reset_n(reset_n),
    .main_power_ok(main_power_ok), .module_fitted(module_fitted), .scan_req(scan_req),
    .scan_time(scan_time), .scan_valid(scan_valid), .preset_req(preset_req),
    .preset_time(preset_time), .preset_status(preset_status), .preset_done(preset_done),
    .summary_warning_word(summary_warning_word), .clock_fault(clock_fault));
  pcc_cpu_model u_cpu (.clk(clk), .reset_n(reset_n), .scan_req(scan_req),
    .scan_time(scan_time), .scan_valid(scan_valid), .last(last), .n_rec(n_rec));
  // Free-running 100 MHz clock.
  initial
  begin
    forever #5 clk = ~clk;
  end
  // Builds a BCD record from decimal fields.
  function automatic pcc_time_s mk(input int y, mo, d, h, mi, s, w, c);
    int v[8] = '{y, mo, d, h, mi, s, w, c};
    for (int i = 0; i < 8; i++)
      mk.field[i] = {4'(v[i] / 10), 4'(v[i] % 10)};
  endfunction : mk
  task automatic finish_test();
    $display("Counts: %0d mismatches in %0d comparisons", n_fail, comparisons);
    if (n_fail == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : finish_test
  task automatic chk_t(input pcc_time_s g, input pcc_time_s e);
    comparisons++;
    if (g !== e)
    begin
      n_fail++;
      $display("BAD %0t record %h expected %h", $time, g, e);
    end
  endtask : chk_t
  task automatic chk_v(input logic [15:0] g, input logic [15:0] e);
    comparisons++;
    if (g !== e)
    begin
      n_fail++;
      $display("BAD %0t value %h expected %h", $time, g, e);
    end
  endtask : chk_v
  task automatic chk_fault(input logic f);
    chk_v(16'(clock_fault), 16'(f));
    chk_v(summary_warning_word, {11'h000, f, 4'h0});
  endtask : chk_fault
  // Waits for two fresh records so the copy postdates the call.
  task automatic read_time(output pcc_time_s r);
    int base;
    #1;
    base = n_rec;
    for (int i = 0; i < 40 && n_rec < base + 2; i++)
    begin
      @(posedge clk);
      #1;
    end
    if (n_rec < base + 2)
    begin
      n_fail++;
      $display("BAD %0t no scan record", $time);
      finish_test();
    end
    r = last;
  endtask : read_time
  task automatic preset(input pcc_time_s v, input logic [7:0] st);
    @(posedge clk);
    preset_time <= v;
    preset_req <= 1'b1;
    @(posedge clk);
    preset_req <= 1'b0;
    #1;
    chk_v(16'(preset_done), 16'h0001);
    chk_v(16'(preset_status), 16'(st));
  endtask : preset
  task automatic tick_case(input pcc_time_s s, input pcc_time_s e);
    preset(s, PCC_ST_OK);
    repeat (SEC) @(posedge clk);
    read_time(got);
    chk_t(got, e);
  endtask : tick_case
  initial
  begin
    void'($urandom(32'h76fe));
    repeat (12) @(posedge clk);
    reset_n <= 1'b1;
    read_time(got);
    chk_t(got, '0);
    chk_fault(1'b1);
    // Carries through every field, month lengths and leap years.
    tick_case(mk(24, 5, 5, 12, 34, 56, 2, 20), mk(24, 5, 5, 12, 34, 57, 2, 20));
    tick_case(mk(99, 12, 31, 23, 59, 59, 6, 19), mk(0, 1, 1, 0, 0, 0, 0, 20));
    tick_case(mk(1, 2, 28, 23, 59, 59, 3, 20), mk(1, 3, 1, 0, 0, 0, 4, 20));
    tick_case(mk(4, 2, 28, 23, 59, 59, 5, 20), mk(4, 2, 29, 0, 0, 0, 6, 20));
    tick_case(mk(0, 2, 28, 23, 59, 59, 1, 20), mk(0, 2, 29, 0, 0, 0, 2, 20));
    tick_case(mk(7, 4, 30, 23, 59, 59, 0, 20), mk(7, 5, 1, 0, 0, 0, 1, 20));
    tick_case(mk(7, 1, 31, 10, 59, 59, 0, 20), mk(7, 1, 31, 11, 0, 0, 0, 20));
    // Random valid presets read back whole; one also tries an absent module.
    for (int i = 0; i < 20; i++)
    begin
      t = mk($urandom % 100, 1 + $urandom % 12, 1 + $urandom % 31, $urandom % 24,
        $urandom % 60, $urandom % 60, $urandom % 7, $urandom % 100);
      preset(t, PCC_ST_OK);
      chk_fault(1'b0);
      if (i == 5)
      begin
        @(posedge clk) module_fitted <= 1'b0;
        preset(mk(1, 1, 1, 1, 1, 1, 1, 1), PCC_ST_ABSENT);
        @(posedge clk) module_fitted <= 1'b1;
      end
      read_time(got);
      chk_t(got, t);
    end
    // Improper data flags a fault and halts; a good preset recovers.
    for (int i = 0; i < 9; i++)
    begin
      t = mk(10, 6, 15, 8, 0, 0, 3, 20);
      t.field[bad_f[i]] = bad_v[i];
      preset(t, PCC_ST_BAD);
      chk_fault(1'b1);
      repeat (2 * SEC) @(posedge clk);
      read_time(got);
      chk_t(got, t);
      preset(mk(10, 6, 15, 8, 0, 0, 3, 20), PCC_ST_OK);
      chk_fault(1'b0);
    end
    // Power loss blocks scans but timekeeping carries on.
    @(posedge clk) main_power_ok <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    k = n_rec;
    repeat (26) @(posedge clk);
    #1;
    chk_v(16'(n_rec), 16'(k));
    @(posedge clk) main_power_ok <= 1'b1;
    repeat (10) @(posedge clk);
    read_time(got);
    chk_t(got, mk(10, 6, 15, 8, 0, 2, 3, 20));
    finish_test();
  end
endmodule : tb_pcc_calendar_clock
bind pcc_calendar_clock pcc_props #(.SEC_CYCLES(SEC_CYCLES)) u_props (.clk(clk),
  .reset_n(reset_n), .main_power_ok(main_power_ok), .module_fitted(module_fitted),
  .scan_req(scan_req), .preset_req(preset_req), .preset_time(preset_time),
  .scan_time(scan_time), .scan_valid(scan_valid), .preset_status(preset_status),
  .preset_done(preset_done), .summary_warning_word(summary_warning_word),
  .clock_fault(clock_fault));
